/* rtl/event_bank.sv */
`timescale 1ns/1ps
`include "hq_cfg.svh"

// sticky event flags, write-one-to-clear, with a mask onto one level irq
module event_bank (
  input  wire logic clk,
  input  wire logic reset_n,
  evt_if.bank       ev,
  output      logic irq
);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev.status <= 16'h0000;
    end else begin
      // a set in the same cycle as its clear survives
      ev.status <= (ev.status & ~ev.clear) | ev.set;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev.mask <= `INT_MASK_RESET;
    end else if (ev.mask_write) begin
      ev.mask <= ev.mask_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ev.status & ~ev.clear) | ev.set) & ev.mask);
    end
  end

endmodule

/* rtl/evt_if.sv */
`timescale 1ns/1ps

interface evt_if;
  logic [15:0] set;
  logic [15:0] clear;
  logic        mask_write;
  logic [15:0] mask_data;
  logic [15:0] status;
  logic [15:0] mask;

  modport bank (
    input  set,
    input  clear,
    input  mask_write,
    input  mask_data,
    output status,
    output mask
  );

  modport ctrl (
    output set,
    output clear,
    output mask_write,
    output mask_data,
    input  status,
    input  mask
  );
endinterface

/* rtl/host_queue_command_status.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "hq_cfg.svh"

// Operation
// RULE1: byte count register shows head frame size in bits 11-0, read-only.
// RULE2: on an 8-bit host bus the low byte is read before the high byte.
// RULE3: one byte count per pending frame; each read advances to the next frame.
// RULE4: memory monitor set raises interrupt bit 6 once transmit space suffices.
// RULE5: memory monitor bit clears itself when the frame finishes transmitting.
// RULE6: writing one to manual enqueue queues exactly one transmit frame.
// RULE7: manual enqueue bit clears itself when that transmission completes.
// RULE8: duration status shows the timer since first queued frame passed its threshold.
// RULE9: the three threshold status bits refresh only on writing one to interrupt bit 13.
// RULE10: byte threshold status shows queued bytes exceeded the byte threshold.
// RULE11: frame threshold status shows queued frames exceeded the frame threshold.
// RULE12: header offset enable inserts two bytes before each received frame header.
// RULE13: duration enable raises interrupt bit 13 once the duration threshold is passed.
// RULE14: writes to read-only fields change nothing; pending command bits read one.
module host_queue_command_status
  import hq_pkg::*;
#(
  parameter int DURATION_UNIT_CYCLES = `DURATION_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // receive queue state from the switch datapath
  input  wire logic [11:0] rx_head_byte_count,
  input  wire logic [15:0] rx_queue_bytes,
  input  wire logic [7:0]  rx_frame_count_reg,
  output      logic        rx_count_advance,
  output      logic        header_offset_enable,
  // transmit queue state
  input  wire logic [12:0] tx_free_space,
  input  wire logic        tx_frame_done,
  output      logic        tx_enqueue_req,
  // interrupt
  output      logic        irq
);

  // the unit counter is 16 bits wide
  if (DURATION_UNIT_CYCLES < 1 || DURATION_UNIT_CYCLES > 65536) begin : bad_unit
    $error("DURATION_UNIT_CYCLES must lie between one and 65536");
  end

  evt_if ev ();

  event_bank u_event_bank (
    .clk     (clk),
    .reset_n (reset_n),
    .ev      (ev),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // apb decode: one wait state, then the answer
  // ----------------------------------------------------------------
  reg_index_t    index;
  logic          mapped;
  logic          access;
  logic          wr_done;
  logic          rd_done;
  reg16_t        wdata;

  reg16_t        tx_queue_command;
  reg16_t        tx_queue_command_view;
  reg16_t        rx_queue_command;
  reg16_t        rx_duration_threshold;
  reg16_t        rx_byte_threshold;
  reg16_t        rx_frame_threshold;
  reg16_t        tx_next_size_request;
  reg16_t        rx_frame_byte_count;
  reg16_t        read_value;
  tx_cmd_state_t tx_state;
  logic          monitor_armed;
  logic          monitor_fired;
  logic [15:0]   duration_timer;
  logic [15:0]   unit_count;
  logic          unit_tick;

  assign index   = paddr[11:2];
  assign wdata   = pwdata[15:0];
  assign access  = psel && penable && pready;
  assign wr_done = access && pwrite && mapped;
  assign rd_done = access && !pwrite && mapped;

  always_comb begin
    mapped     = 1'b1;
    read_value = 16'h0000;
    unique case (index)
      `IDX_RX_FRAME_BYTE_COUNT: read_value = rx_frame_byte_count;
      `IDX_TX_QUEUE_COMMAND:    read_value = tx_queue_command_view;
      `IDX_RX_QUEUE_COMMAND:    read_value = rx_queue_command;
      `IDX_RX_DURATION_THRESH:  read_value = rx_duration_threshold;
      `IDX_RX_BYTE_THRESH:      read_value = rx_byte_threshold;
      `IDX_INT_STATUS:          read_value = ev.status;
      `IDX_INT_MASK:            read_value = ev.mask;
      `IDX_RX_FRAME_THRESH:     read_value = rx_frame_threshold;
      `IDX_TX_NEXT_SIZE_REQ:    read_value = tx_next_size_request;
      default:                  mapped     = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (mapped && !pwrite) ? {16'h0000, read_value} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive byte count of the head frame
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_frame_byte_count <= 16'h0000;
    end else begin
      rx_frame_byte_count <= {4'h0, rx_head_byte_count}; // [RULE1]
    end
  end

  // the whole count is one 32-bit read here, so low-then-high order is moot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_count_advance <= 1'b0;
    end else begin
      rx_count_advance <= rd_done && (index == `IDX_RX_FRAME_BYTE_COUNT)
                          && (rx_frame_count_reg != 8'h00); // [RULE3] [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // transmit queue command
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state       <= tx_idle;
      tx_enqueue_req <= 1'b0;
    end else begin
      tx_enqueue_req <= 1'b0;
      unique case (tx_state)
        tx_idle: begin
          if (wr_done && index == `IDX_TX_QUEUE_COMMAND && wdata[`TXQ_MANUAL_ENQUEUE]) begin
            tx_enqueue_req <= 1'b1; // [RULE6]
            tx_state       <= tx_enqueue_pending;
          end
        end
        tx_enqueue_pending: begin
          // further writes of one are ignored: one frame per command
          if (tx_frame_done) begin
            tx_state <= tx_idle; // [RULE7]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_armed <= 1'b0;
      monitor_fired <= 1'b0;
    end else if (tx_frame_done) begin
      monitor_armed <= 1'b0; // [RULE5]
      monitor_fired <= 1'b0;
    end else if (wr_done && index == `IDX_TX_QUEUE_COMMAND && wdata[`TXQ_MEMORY_MONITOR]) begin
      monitor_armed <= 1'b1;
      monitor_fired <= monitor_armed && monitor_fired;
    end else if (monitor_armed && !monitor_fired
                 && {3'b000, tx_free_space} >= tx_next_size_request) begin
      monitor_fired <= 1'b1; // [RULE4]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_queue_command <= `TXQ_RESET;
    end else if (wr_done && index == `IDX_TX_QUEUE_COMMAND) begin
      tx_queue_command <= {wdata[15:2], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // receive queue command and threshold registers
  // ----------------------------------------------------------------
  logic refresh;
  assign refresh = wr_done && index == `IDX_INT_STATUS && wdata[`INT_RX];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_queue_command <= `RXQ_RESET;
    end else begin
      if (wr_done && index == `IDX_RX_QUEUE_COMMAND) begin
        rx_queue_command <= (wdata & `RXQ_WRITE_MASK)
                            | (rx_queue_command & ~`RXQ_WRITE_MASK); // [RULE14]
      end
      if (refresh) begin // [RULE9]
        rx_queue_command[`RXQ_DURATION_STAT] <=
          duration_timer > rx_duration_threshold; // [RULE8]
        rx_queue_command[`RXQ_BYTE_THRESH_STAT] <=
          rx_queue_bytes > rx_byte_threshold; // [RULE10]
        rx_queue_command[`RXQ_FRAME_THRESH_STAT] <=
          {8'h00, rx_frame_count_reg} > rx_frame_threshold; // [RULE11]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_duration_threshold <= `THRESH_RESET;
      rx_byte_threshold     <= `THRESH_RESET;
      rx_frame_threshold    <= `THRESH_RESET;
      tx_next_size_request  <= `THRESH_RESET;
    end else if (wr_done) begin
      if (index == `IDX_RX_DURATION_THRESH) rx_duration_threshold <= wdata;
      if (index == `IDX_RX_BYTE_THRESH)     rx_byte_threshold     <= wdata;
      if (index == `IDX_RX_FRAME_THRESH)    rx_frame_threshold    <= wdata;
      if (index == `IDX_TX_NEXT_SIZE_REQ)   tx_next_size_request  <= wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      header_offset_enable <= 1'b0;
    end else begin
      header_offset_enable <= rx_queue_command[`RXQ_HEADER_OFFSET]; // [RULE12]
    end
  end

  // ----------------------------------------------------------------
  // duration timer: runs while any frame waits, in microsecond units
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unit_count <= 16'h0000;
      unit_tick  <= 1'b0;
    end else if (unit_count >= 16'(DURATION_UNIT_CYCLES - 1)) begin
      unit_count <= 16'h0000;
      unit_tick  <= 1'b1;
    end else begin
      unit_count <= unit_count + 16'h0001;
      unit_tick  <= 1'b0;
    end
  end

  // saturates so a long wait cannot wrap back under the threshold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duration_timer <= 16'h0000;
    end else if (rx_frame_count_reg == 8'h00) begin
      duration_timer <= 16'h0000;
    end else if (unit_tick && duration_timer != 16'hFFFF) begin
      duration_timer <= duration_timer + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // events into the sticky status bank
  // ----------------------------------------------------------------
  logic duration_hit;
  logic duration_hit_d;
  assign duration_hit = rx_queue_command[`RXQ_DURATION_ENABLE]
                        && duration_timer > rx_duration_threshold;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duration_hit_d <= 1'b0;
    end else begin
      duration_hit_d <= duration_hit;
    end
  end

  logic monitor_fire_now;
  assign monitor_fire_now = monitor_armed && !monitor_fired && !tx_frame_done
                            && {3'b000, tx_free_space} >= tx_next_size_request;

  always_comb begin
    ev.set                  = 16'h0000;
    ev.set[`INT_RX]         = duration_hit && !duration_hit_d; // [RULE13]
    ev.set[`INT_TX_SPACE]   = monitor_fire_now; // [RULE4]
    ev.clear                = (wr_done && index == `IDX_INT_STATUS) ? wdata : 16'h0000;
    ev.mask_write           = wr_done && index == `IDX_INT_MASK;
    ev.mask_data            = wdata;
  end

  // pending self-clearing bits read back as one
  always_comb begin
    tx_queue_command_view = tx_queue_command;
    tx_queue_command_view[`TXQ_MANUAL_ENQUEUE] = (tx_state == tx_enqueue_pending); // [RULE14]
    tx_queue_command_view[`TXQ_MEMORY_MONITOR] = monitor_armed;
  end

endmodule

/* rtl/hq_cfg.svh */
`ifndef HQ_CFG_SVH
`define HQ_CFG_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_RX_FRAME_BYTE_COUNT 10'h17E
`define IDX_TX_QUEUE_COMMAND    10'h180
`define IDX_RX_QUEUE_COMMAND    10'h182
`define IDX_RX_DURATION_THRESH  10'h18C
`define IDX_RX_BYTE_THRESH      10'h18E
`define IDX_INT_STATUS          10'h190
`define IDX_INT_MASK            10'h192
`define IDX_RX_FRAME_THRESH     10'h19C
`define IDX_TX_NEXT_SIZE_REQ    10'h19E

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TXQ_MANUAL_ENQUEUE      0
`define TXQ_MEMORY_MONITOR      1
`define RXQ_DURATION_ENABLE     7
`define RXQ_HEADER_OFFSET       9
`define RXQ_FRAME_THRESH_STAT   10
`define RXQ_BYTE_THRESH_STAT    11
`define RXQ_DURATION_STAT       12
`define INT_TX_SPACE            6
`define INT_RX                  13
`define BYTE_COUNT_MSB          11

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define TXQ_RESET               16'h0000
`define RXQ_RESET               16'h0000
`define RXQ_WRITE_MASK          16'hE3FF
`define THRESH_RESET            16'h0000
`define INT_MASK_RESET          16'h0000

// ----------------------------------------------------------------
// timing: duration timer counts in units of one microsecond
// ----------------------------------------------------------------
`define CLK_PERIOD_NS           40
`define DURATION_UNIT_NS        1000
`define DURATION_UNIT_CYCLES    (`DURATION_UNIT_NS / `CLK_PERIOD_NS)

`endif

/* rtl/hq_pkg.sv */
package hq_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [9:0]  reg_index_t;

  typedef enum logic [1:0] {
    tx_idle,
    tx_enqueue_pending
  } tx_cmd_state_t;

endpackage

/* verification/dp_model.sv */
`timescale 1ns/1ps
// switch datapath stand-in: three frames queued, transmit takes DONE_DELAY cycles
module dp_model #(
  parameter int DONE_DELAY = 100
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        rx_count_advance,
  input  wire logic        tx_enqueue_req,
  output      logic [11:0] rx_head_byte_count,
  output      logic [15:0] rx_queue_bytes,
  output      logic [7:0]  rx_frame_count_reg,
  output      logic        tx_frame_done
);
  int wait_cnt;
  // frame size encodes the queue depth so each advance is visible to the host
  assign rx_head_byte_count = {rx_frame_count_reg[3:0], 8'hA3};
  assign rx_queue_bytes     = {rx_frame_count_reg, 8'h00};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_frame_count_reg <= 8'h03;
    end else if (rx_count_advance && rx_frame_count_reg != 8'h00) begin
      rx_frame_count_reg <= rx_frame_count_reg - 8'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt      <= 0;
      tx_frame_done <= 1'b0;
    end else begin
      tx_frame_done <= (wait_cnt == 1);
      if (tx_enqueue_req) begin
        wait_cnt <= DONE_DELAY;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

/* verification/hq_monitor.sv */
`timescale 1ns/1ps
`include "hq_cfg.svh"
module hq_monitor #(
  parameter int DURATION_UNIT_CYCLES = 1
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] rx_head_byte_count,
  input wire logic [7:0]  rx_frame_count_reg,
  input wire logic        rx_count_advance,
  input wire logic        header_offset_enable,
  input wire logic        tx_enqueue_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------
  // completed accesses
  // --------------------------------
  sequence take_s;
    psel && penable && pready;
  endsequence
  sequence rd_count_s;
    take_s ##0 (!pwrite && paddr[11:2] == `IDX_RX_FRAME_BYTE_COUNT && !pslverr);
  endsequence
  sequence wr_rxq_s;
    take_s ##0 (pwrite && paddr[11:2] == `IDX_RX_QUEUE_COMMAND);
  endsequence
  AST_WAIT_STATE: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access cycle");
  AST_SETUP_QUIET: assert property (psel && !penable |-> !pready)
    else $error("pready during setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_COUNT_VALUE: assert property (rd_count_s |-> prdata == {20'h0_0000, $past(rx_head_byte_count, 2)})
    else $error("byte count read wrong");
  AST_ADVANCE_AFTER_READ: assert property (rd_count_s ##0 (rx_frame_count_reg != 8'h00) |=> rx_count_advance)
    else $error("no advance after count read");
  AST_ADVANCE_CAUSE: assert property (rx_count_advance |-> $past(psel && penable && pready && !pwrite))
    else $error("advance without read");
  AST_ENQ_PULSE: assert property (tx_enqueue_req |=> !tx_enqueue_req)
    else $error("enqueue request longer than one cycle");
  AST_ENQ_CAUSE: assert property (tx_enqueue_req |-> $past(psel && penable && pready && pwrite && pwdata[0]))
    else $error("enqueue request without command");
  AST_HDR_COPY: assert property (wr_rxq_s |-> ##2 header_offset_enable == $past(pwdata[9], 2))
    else $error("header offset enable not following register");
endmodule

bind host_queue_command_status hq_monitor #(.DURATION_UNIT_CYCLES(DURATION_UNIT_CYCLES)) i_hq_monitor (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_head_byte_count(rx_head_byte_count), .rx_frame_count_reg(rx_frame_count_reg),
  .rx_count_advance(rx_count_advance), .header_offset_enable(header_offset_enable),
  .tx_enqueue_req(tx_enqueue_req)
);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "hq_cfg.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] rx_head_byte_count;
  logic [15:0] rx_queue_bytes;
  logic [7:0]  rx_frame_count_reg;
  logic        rx_count_advance;
  logic        header_offset_enable;
  logic [12:0] tx_free_space = 13'h0080;
  logic        tx_frame_done;
  logic        tx_enqueue_req;
  logic        irq;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [31:0] enq_count = 32'h0000_0000;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  host_queue_command_status #(.DURATION_UNIT_CYCLES(1)) i_host_queue_command_status (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_head_byte_count(rx_head_byte_count), .rx_queue_bytes(rx_queue_bytes),
    .rx_frame_count_reg(rx_frame_count_reg), .rx_count_advance(rx_count_advance),
    .header_offset_enable(header_offset_enable), .tx_free_space(tx_free_space),
    .tx_frame_done(tx_frame_done), .tx_enqueue_req(tx_enqueue_req), .irq(irq));

  dp_model i_dp_model (
    .clk(clk), .reset_n(reset_n), .rx_count_advance(rx_count_advance),
    .tx_enqueue_req(tx_enqueue_req), .rx_head_byte_count(rx_head_byte_count),
    .rx_queue_bytes(rx_queue_bytes), .rx_frame_count_reg(rx_frame_count_reg),
    .tx_frame_done(tx_frame_done));

  always @(posedge clk) begin
    if (tx_enqueue_req === 1'b1) enq_count <= enq_count + 32'h0000_0001;
  end

  // --------------------------------
  // checking and bus tasks
  // --------------------------------
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask

  // called just after a rising edge; the request stands until pready is seen at an edge,
  // and one idle edge follows the release so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_rd(input string n, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(n, exp, rd_data);
  endtask

  task automatic poll(input string n, input logic [9:0] idx, input logic [31:0] m);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, idx, 32'h0000_0000);
      if ((rd_data & m) === m) break;
    end
    chk(n, m, rd_data & m);
  endtask

  task automatic chk_pin(input string n, ref logic sig, input logic exp);
    @(negedge clk);
    chk(n, {31'h0000_0000, exp}, {31'h0000_0000, sig});
    @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_rd("txq reset", `IDX_TX_QUEUE_COMMAND, 32'h0000_0000);
    chk_rd("rxq reset", `IDX_RX_QUEUE_COMMAND, 32'h0000_0000);
    chk_rd("byte count", `IDX_RX_FRAME_BYTE_COUNT, 32'h0000_03A3);
    apb(1'b1, `IDX_RX_FRAME_BYTE_COUNT, 32'h0000_FFFF);
    chk_rd("next byte count", `IDX_RX_FRAME_BYTE_COUNT, 32'h0000_02A3);
    apb(1'b1, `IDX_RX_DURATION_THRESH, 32'h0000_0002);
    apb(1'b1, `IDX_RX_BYTE_THRESH, 32'h0000_0050);
    apb(1'b1, `IDX_RX_FRAME_THRESH, 32'h0000_0000);
    apb(1'b1, `IDX_RX_QUEUE_COMMAND, 32'h0000_1E80);
    chk_pin("header offset", header_offset_enable, 1'b1);
    poll("duration event", `IDX_INT_STATUS, 32'h0000_2000);
    chk_rd("stale status", `IDX_RX_QUEUE_COMMAND, 32'h0000_0280);
    apb(1'b1, `IDX_INT_STATUS, 32'h0000_2000);
    chk_rd("threshold status", `IDX_RX_QUEUE_COMMAND, 32'h0000_1E80);
    apb(1'b1, `IDX_RX_QUEUE_COMMAND, 32'h0000_0000);
    chk_pin("header offset off", header_offset_enable, 1'b0);
    apb(1'b1, `IDX_TX_NEXT_SIZE_REQ, 32'h0000_0100);
    apb(1'b1, `IDX_INT_MASK, 32'h0000_0040);
    apb(1'b1, `IDX_TX_QUEUE_COMMAND, 32'h0000_0001);
    chk_rd("enqueue pending", `IDX_TX_QUEUE_COMMAND, 32'h0000_0001);
    apb(1'b1, `IDX_TX_QUEUE_COMMAND, 32'h0000_0003);
    chk_rd("monitor armed", `IDX_TX_QUEUE_COMMAND, 32'h0000_0003);
    chk("enqueue pulses", 32'h0000_0001, enq_count);
    chk_pin("irq quiet", irq, 1'b0);
    tx_free_space <= 13'h0200;
    poll("space event", `IDX_INT_STATUS, 32'h0000_0040);
    chk_pin("irq raised", irq, 1'b1);
    apb(1'b1, `IDX_INT_STATUS, 32'h0000_0040);
    chk_pin("irq cleared", irq, 1'b0);
    // read first: the last write left rd_data at zero, which would end the wait at once
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, `IDX_TX_QUEUE_COMMAND, 32'h0000_0000);
      if (rd_data === 32'h0000_0000) break;
    end
    chk("command self clear", 32'h0000_0000, rd_data);
    apb(1'b0, 10'h3FF, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rd_err});
    close_out();
  end
endmodule
